// ===== core/low_address_buffer_decode.sv
// Purpose: Low address slice, bits 11:0, routing local, X, system and memory buses
// Assumes: All inputs synchronous to mclk; bus-control inputs active high
// Notes:   Every bus output and enable is registered, one mclk behind its inputs
//
// Behaviour
// - Bits 0 to 11 of local, X, system and memory address buses are joined through muxes steered by bus controls.
// - With the relocation strap high, a peripheral select is active only while the low I/O space qualifier is active and its address matches.
// - Port pair select covers 022h and 023h, keyboard select 060h and 064h, port B select only 061h.
// - NMI mask select covers 070h and coprocessor select every address 0e0h through 0ffh.
// - A low relocation strap drops the qualifier and bits 11:10 from the select decodes.
// - Hold acknowledge drives X onto system, memory and local; bus master drives system onto X, memory, local.
// - AT cycle drives latched local 11:2 onto system and X 11:2 and memory 11:4, and X 1:0 onto system 1:0.
// - During refresh the refresh row counter is driven onto the system bus.
// - The refresh row counter advances by one per refresh operation.
// - With no control active the local address drives the memory bus.

`timescale 1ns/10ps

module low_address_buffer_decode (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Bus control
    input  wire logic        dma_hold_acknowledge,
    input  wire logic        bus_master,
    input  wire logic        refresh,
    input  wire logic        at_cycle_enable,
    input  wire logic        memory_address_latch_strobe,
    // Decode qualification
    input  wire logic        low_io_space_qualifier,
    input  wire logic        relocation_strap,
    // Local CPU address bus
    input  wire logic [11:0] local_addr_in,
    output logic      [11:0] local_addr_out,
    output logic      [11:0] local_addr_oe_n,
    // Peripheral X address bus
    input  wire logic [11:0] peripheral_x_address_bus_in,
    output logic      [11:0] peripheral_x_address_bus_out,
    output logic      [11:0] peripheral_x_address_bus_oe_n,
    // System address bus
    input  wire logic [11:0] system_address_bus_in,
    output logic      [11:0] system_address_bus_out,
    output logic      [11:0] system_address_bus_oe_n,
    // Memory address bus
    output logic      [11:0] memory_address_bus,
    output logic      [11:0] memory_address_bus_oe_n,
    // Peripheral selects, active high
    output logic             io_port_pair_select,
    output logic             keyboard_ctrl_select,
    output logic             port_b_select,
    output logic             nmi_mask_select,
    output logic             math_coproc_select
);

    logic [11:0]          cpu_addr;
    logic [11:0]          refresh_row;
    lab_pkg::route_mode_e mode;

    // Selects decoded combinationally, registered below
    logic dec_pair;
    logic dec_kbd;
    logic dec_pb;
    logic dec_nmi;
    logic dec_cop;

    // Next values for the bus drivers
    logic [11:0] next_local;
    logic [11:0] next_local_oe_n;
    logic [11:0] next_x;
    logic [11:0] next_x_oe_n;
    logic [11:0] next_sys;
    logic [11:0] next_sys_oe_n;
    logic [11:0] next_mem;
    logic [11:0] next_mem_oe_n;

    // CPU address is loaded on each enabled mclk edge while the strobe is high and holds after its
    // trailing edge, so CPU-sourced paths see a steady address for the cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_addr <= lab_pkg::ADDR_RESET;
        end else if (clk_en && memory_address_latch_strobe) begin
            cpu_addr <= local_addr_in;
        end
    end

    refresh_row_counter u_refresh_row_counter (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .refresh (refresh),
        .row     (refresh_row)
    );

    assign mode = dma_hold_acknowledge ? lab_pkg::MODE_HOLD    :
                  bus_master           ? lab_pkg::MODE_MASTER  :
                  refresh              ? lab_pkg::MODE_REFRESH :
                  at_cycle_enable      ? lab_pkg::MODE_AT      :
                                         lab_pkg::MODE_DEFAULT;

    // Decode watches whichever address owns the cycle; the X bus during DMA,
    // the system bus under a master, otherwise the latched CPU address
    wire [11:0] decode_addr = (mode == lab_pkg::MODE_HOLD)   ? peripheral_x_address_bus_in :
                              (mode == lab_pkg::MODE_MASTER) ? system_address_bus_in       :
                                                               cpu_addr;

    chip_select_decode u_chip_select_decode (
        .addr                   (decode_addr),
        .low_io_space_qualifier (low_io_space_qualifier),
        .relocation_strap       (relocation_strap),
        .io_port_pair_select    (dec_pair),
        .keyboard_ctrl_select   (dec_kbd),
        .port_b_select          (dec_pb),
        .nmi_mask_select        (dec_nmi),
        .math_coproc_select     (dec_cop)
    );

    // AT-cycle views of the addresses; the low two system bits come from X
    wire [11:0] at_sys_addr = {cpu_addr[11:lab_pkg::AT_LOCAL_LO],
                               peripheral_x_address_bus_in[lab_pkg::AT_LOCAL_LO-1:0]};
    wire [11:0] at_x_oe_n   = {{(12-lab_pkg::AT_LOCAL_LO){1'b0}}, {lab_pkg::AT_LOCAL_LO{1'b1}}};
    wire [11:0] at_mem_oe_n = {{(12-lab_pkg::AT_MEM_LO){1'b0}}, {lab_pkg::AT_MEM_LO{1'b1}}};

    always_comb begin
        next_local      = local_addr_out;
        next_x          = peripheral_x_address_bus_out;
        next_sys        = system_address_bus_out;
        next_mem        = memory_address_bus;
        next_local_oe_n = lab_pkg::OE_N_OFF;
        next_x_oe_n     = lab_pkg::OE_N_OFF;
        next_sys_oe_n   = lab_pkg::OE_N_OFF;
        next_mem_oe_n   = lab_pkg::OE_N_OFF;
        case (mode)
            lab_pkg::MODE_HOLD: begin
                next_sys        = peripheral_x_address_bus_in;
                next_mem        = peripheral_x_address_bus_in;
                next_local      = peripheral_x_address_bus_in;
                next_sys_oe_n   = lab_pkg::OE_N_ON;
                next_mem_oe_n   = lab_pkg::OE_N_ON;
                next_local_oe_n = lab_pkg::OE_N_ON;
            end
            lab_pkg::MODE_MASTER: begin
                next_x          = system_address_bus_in;
                next_mem        = system_address_bus_in;
                next_local      = system_address_bus_in;
                next_x_oe_n     = lab_pkg::OE_N_ON;
                next_mem_oe_n   = lab_pkg::OE_N_ON;
                next_local_oe_n = lab_pkg::OE_N_ON;
            end
            lab_pkg::MODE_REFRESH: begin
                next_sys        = refresh_row;
                next_sys_oe_n   = lab_pkg::OE_N_ON;
            end
            lab_pkg::MODE_AT: begin
                next_sys        = at_sys_addr;
                next_sys_oe_n   = lab_pkg::OE_N_ON;
                next_x          = cpu_addr;
                next_x_oe_n     = at_x_oe_n;
                next_mem        = cpu_addr;
                next_mem_oe_n   = at_mem_oe_n;
            end
            lab_pkg::MODE_DEFAULT: begin
                next_mem        = cpu_addr;
                next_mem_oe_n   = lab_pkg::OE_N_ON;
            end
            default: begin
                next_mem        = cpu_addr;
                next_mem_oe_n   = lab_pkg::OE_N_ON;
            end
        endcase
    end

    // Bus drivers; registering costs a cycle but keeps every output glitch free
    // while the control inputs change together
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            local_addr_out                <= lab_pkg::ADDR_RESET;
            local_addr_oe_n               <= lab_pkg::OE_N_OFF;
            peripheral_x_address_bus_out  <= lab_pkg::ADDR_RESET;
            peripheral_x_address_bus_oe_n <= lab_pkg::OE_N_OFF;
            system_address_bus_out        <= lab_pkg::ADDR_RESET;
            system_address_bus_oe_n       <= lab_pkg::OE_N_OFF;
            memory_address_bus            <= lab_pkg::ADDR_RESET;
            memory_address_bus_oe_n       <= lab_pkg::OE_N_OFF;
        end else if (clk_en) begin
            local_addr_out                <= next_local;
            local_addr_oe_n               <= next_local_oe_n;
            peripheral_x_address_bus_out  <= next_x;
            peripheral_x_address_bus_oe_n <= next_x_oe_n;
            system_address_bus_out        <= next_sys;
            system_address_bus_oe_n       <= next_sys_oe_n;
            memory_address_bus            <= next_mem;
            memory_address_bus_oe_n       <= next_mem_oe_n;
        end
    end

    // Registered selects; during refresh the bus carries a row, not a port
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            io_port_pair_select  <= 1'b0;
            keyboard_ctrl_select <= 1'b0;
            port_b_select        <= 1'b0;
            nmi_mask_select      <= 1'b0;
            math_coproc_select   <= 1'b0;
        end else if (clk_en) begin
            io_port_pair_select  <= dec_pair & (mode != lab_pkg::MODE_REFRESH);
            keyboard_ctrl_select <= dec_kbd  & (mode != lab_pkg::MODE_REFRESH);
            port_b_select        <= dec_pb   & (mode != lab_pkg::MODE_REFRESH);
            nmi_mask_select      <= dec_nmi  & (mode != lab_pkg::MODE_REFRESH);
            math_coproc_select   <= dec_cop  & (mode != lab_pkg::MODE_REFRESH);
        end
    end

endmodule : low_address_buffer_decode

// ===== core/lab_pkg.sv
// Purpose: Shared constants and types for the low address buffer and decode slice
// Assumes: Address slice is twelve bits wide, bits 11 down to 0
// Notes:   Port addresses are the standard on-board peripheral locations

package lab_pkg;

    // Slice width
    localparam int          ADDR_W            = 12;

    // Peripheral addresses
    localparam logic [11:0] IO_PAIR_ADDR      = 12'h022;  // Pair 022h and 023h
    localparam logic [11:0] KBD_DATA_ADDR     = 12'h060;
    localparam logic [11:0] KBD_CMD_ADDR      = 12'h064;
    localparam logic [11:0] PORT_B_ADDR       = 12'h061;
    localparam logic [11:0] NMI_MASK_ADDR     = 12'h070;
    localparam logic [11:0] COPROC_LO_ADDR    = 12'h0e0;
    localparam logic [11:0] COPROC_HI_ADDR    = 12'h0ff;

    // Field positions inside the slice
    localparam int          RELOC_BITS_HI     = 11;       // Bits dropped on relocation
    localparam int          RELOC_BITS_LO     = 10;
    localparam int          AT_LOCAL_LO       = 2;        // Local bits 11:2 in an AT cycle
    localparam int          AT_MEM_LO         = 4;        // Memory bits 11:4 in an AT cycle

    // Reset values
    localparam logic [11:0] REFRESH_ROW_RESET = 12'h000;
    localparam logic [11:0] ADDR_RESET        = 12'h000;
    localparam logic [11:0] OE_N_OFF          = 12'hfff;  // Every bit released
    localparam logic [11:0] OE_N_ON           = 12'h000;  // Every bit driven

    // Routing modes, Gray coded along the priority order
    typedef enum logic [2:0] {
        MODE_DEFAULT = 3'h0,
        MODE_AT      = 3'h1,
        MODE_REFRESH = 3'h3,
        MODE_MASTER  = 3'h2,
        MODE_HOLD    = 3'h6
    } route_mode_e;

endpackage : lab_pkg

// ===== core/refresh_row_counter.sv
// Purpose: Refresh row address counter
// Assumes: Refresh input is synchronous to mclk
// Notes:   Advances once per refresh, at the end of the operation

`timescale 1ns/10ps

module refresh_row_counter (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Refresh request level
    input  wire logic        refresh,
    // Current row
    output logic      [11:0] row
);

    logic refresh_prev;
    wire  refresh_done = refresh_prev & ~refresh;

    // Row stays stable for the whole refresh and steps when it ends,
    // so the address on the bus never changes mid-operation
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            refresh_prev <= 1'b0;
            row          <= lab_pkg::REFRESH_ROW_RESET;
        end else if (clk_en) begin
            refresh_prev <= refresh;
            if (refresh_done) begin
                row <= row + 12'h001;
            end
        end
    end

endmodule : refresh_row_counter

// ===== core/chip_select_decode.sv
// Purpose: Peripheral chip-select decode from the low address slice
// Assumes: Qualifier and strap are active high and active low respectively
// Notes:   Pure combinational; the top registers the results

`timescale 1ns/10ps

module chip_select_decode (
    // Address and qualification
    input  wire logic [11:0] addr,
    input  wire logic        low_io_space_qualifier,
    input  wire logic        relocation_strap,
    // Selects, active high
    output logic             io_port_pair_select,
    output logic             keyboard_ctrl_select,
    output logic             port_b_select,
    output logic             nmi_mask_select,
    output logic             math_coproc_select
);

    // Compare under a care mask; bits cleared in the mask are ignored
    function automatic logic addr_match(input logic [11:0] a, input logic [11:0] ref_addr,
                                        input logic [11:0] care);
        addr_match = ((a ^ ref_addr) & care) == 12'h000;
    endfunction : addr_match

    wire        relocate  = ~relocation_strap;
    wire [11:0] base_care = relocate ? 12'h3ff : 12'hfff;
    wire        qualified = relocate | low_io_space_qualifier;

    wire hit_pair = addr_match(addr, lab_pkg::IO_PAIR_ADDR, base_care & 12'hffe);
    wire hit_kbd  = addr_match(addr, lab_pkg::KBD_DATA_ADDR, base_care) |
                    addr_match(addr, lab_pkg::KBD_CMD_ADDR, base_care);
    wire hit_pb   = addr_match(addr, lab_pkg::PORT_B_ADDR, base_care);
    wire hit_nmi  = addr_match(addr, lab_pkg::NMI_MASK_ADDR, base_care);
    wire hit_cop  = addr_match(addr, lab_pkg::COPROC_LO_ADDR,
                               base_care & ~(lab_pkg::COPROC_HI_ADDR ^ lab_pkg::COPROC_LO_ADDR));

    assign io_port_pair_select  = qualified & hit_pair;
    assign keyboard_ctrl_select = qualified & hit_kbd;
    assign port_b_select        = qualified & hit_pb;
    assign nmi_mask_select      = qualified & hit_nmi;
    assign math_coproc_select   = qualified & hit_cop;

endmodule : chip_select_decode

// ===== verif/lab_chk.sv
// Purpose: Port assertions for the low address slice
// Assumes: One clock domain; outputs follow inputs by one enabled edge
// Notes:   Helper flops mirror the address latch and the last refresh row
`timescale 1ns/10ps
module lab_chk (
    // Clock, reset, enable
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    // Bus control and qualification
    input wire logic        dma_hold_acknowledge,
    input wire logic        bus_master,
    input wire logic        refresh,
    input wire logic        at_cycle_enable,
    input wire logic        memory_address_latch_strobe,
    input wire logic        low_io_space_qualifier,
    input wire logic        relocation_strap,
    // Buses
    input wire logic [11:0] local_addr_in,
    input wire logic [11:0] local_addr_out,
    input wire logic [11:0] local_addr_oe_n,
    input wire logic [11:0] peripheral_x_address_bus_in,
    input wire logic [11:0] peripheral_x_address_bus_out,
    input wire logic [11:0] peripheral_x_address_bus_oe_n,
    input wire logic [11:0] system_address_bus_in,
    input wire logic [11:0] system_address_bus_out,
    input wire logic [11:0] system_address_bus_oe_n,
    input wire logic [11:0] memory_address_bus,
    input wire logic [11:0] memory_address_bus_oe_n,
    // Selects
    input wire logic        io_port_pair_select,
    input wire logic        keyboard_ctrl_select,
    input wire logic        port_b_select,
    input wire logic        nmi_mask_select,
    input wire logic        math_coproc_select
);
    logic [11:0] lat, row_seen;
    logic        ref_q, have_row;
    // Priority-resolved modes, each only on an enabled edge
    wire h = clk_en & dma_hold_acknowledge;
    wire m = clk_en & ~dma_hold_acknowledge & bus_master;
    wire r = clk_en & ~dma_hold_acknowledge & ~bus_master & refresh;
    wire t = clk_en & ~dma_hold_acknowledge & ~bus_master & ~refresh & at_cycle_enable;
    wire d = clk_en & ~(dma_hold_acknowledge | bus_master | refresh | at_cycle_enable);
    // Expected selects, worked out independently of the design's decoder
    wire [11:0] da = dma_hold_acknowledge ? peripheral_x_address_bus_in : bus_master ? system_address_bus_in : lat;
    wire ok = ~relocation_strap | (low_io_space_qualifier & (da[11:10] == 2'h0));
    wire [4:0] sel_exp = {5{ok}} & {da[9:1] == 9'h011, da[9:0] == 10'h060 || da[9:0] == 10'h064,
                                    da[9:0] == 10'h061, da[9:0] == 10'h070, da[9:5] == 5'h07};
    wire [4:0] sel = {io_port_pair_select, keyboard_ctrl_select, port_b_select, nmi_mask_select, math_coproc_select};
    // Latch mirror and the row shown by the previous refresh
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lat      <= lab_pkg::ADDR_RESET;
            ref_q    <= 1'b0;
            row_seen <= lab_pkg::REFRESH_ROW_RESET;
            have_row <= 1'b0;
        end else if (clk_en) begin
            if (memory_address_latch_strobe) lat <= local_addr_in;
            ref_q <= r;
            if (ref_q) row_seen <= system_address_bus_out;
            if (ref_q) have_row <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // The counter steps on the raw refresh level, so a refresh stalled by a frozen edge is not a new one
    sequence ref_begin;
        !refresh && clk_en ##1 r;
    endsequence
    hold_route_a: assert property (h |=> system_address_bus_out == $past(peripheral_x_address_bus_in)
        && memory_address_bus == $past(peripheral_x_address_bus_in) && local_addr_out == $past(peripheral_x_address_bus_in))
        else $error("hold routing wrong");
    master_route_a: assert property (m |=> peripheral_x_address_bus_out == $past(system_address_bus_in)
        && memory_address_bus == $past(system_address_bus_in) && local_addr_out == $past(system_address_bus_in))
        else $error("master routing wrong");
    refresh_drive_a: assert property (r |=> system_address_bus_oe_n == lab_pkg::OE_N_ON
        && memory_address_bus_oe_n == lab_pkg::OE_N_OFF) else $error("refresh enables wrong");
    row_step_a: assert property (ref_begin ##0 have_row |=> system_address_bus_out == row_seen + 12'h001)
        else $error("refresh row did not step");
    at_route_a: assert property (t |=> (system_address_bus_out & 12'hffc) == ($past(lat) & 12'hffc)
        && system_address_bus_out[1:0] == $past(peripheral_x_address_bus_in[1:0])
        && (peripheral_x_address_bus_out & 12'hffc) == ($past(lat) & 12'hffc)
        && (memory_address_bus & 12'hff0) == ($past(lat) & 12'hff0)) else $error("AT routing wrong");
    at_release_a: assert property (t |=> peripheral_x_address_bus_oe_n == 12'h003
        && memory_address_bus_oe_n == 12'h00f && system_address_bus_oe_n == 12'h000) else $error("AT enables wrong");
    default_route_a: assert property (d |=> memory_address_bus == $past(lat)
        && memory_address_bus_oe_n == lab_pkg::OE_N_ON && system_address_bus_oe_n == lab_pkg::OE_N_OFF)
        else $error("default routing wrong");
    sel_decode_a: assert property (clk_en && !r |=> sel == $past(sel_exp))
        else $error("select decode wrong");
    sel_refresh_a: assert property (r |=> sel == 5'h00) else $error("select during refresh");
endmodule : lab_chk
bind low_address_buffer_decode lab_chk chk (.*);

// ===== verif/bus_party.sv
// Purpose: Far-side party on one shared address bus
// Assumes: Per-bit enables, low while the slice drives
// Notes:   An undriven bit shows the far-side value while ext_en is high, else the inverse of its last level
`timescale 1ns/10ps
module bus_party (
    // Clock
    input  wire logic        mclk,
    // Slice side of the pins
    input  wire logic [11:0] dev_out,
    input  wire logic [11:0] dev_oe_n,
    // Far-side driver
    input  wire logic [11:0] ext_val,
    input  wire logic        ext_en,
    // Level on the wires
    output logic      [11:0] lvl
);
    logic [11:0] last = 12'h000;
    // slice owns bits it drives
    // A stale level never passes for a driven one
    assign lvl = (~dev_oe_n & dev_out) | (dev_oe_n & (ext_en ? ext_val : ~last));
    always_ff @(posedge mclk) last <= lvl;
endmodule : bus_party

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the low address slice
// Assumes: One enabled edge of latency on every output
// Notes:   Decode cases run from a table; routing cases are hand-written
`timescale 1ns/10ps
module tb_top;
    logic        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, refresh = 1'b0;
    logic        dma_hold_acknowledge = 1'b0, bus_master = 1'b0, at_cycle_enable = 1'b0;
    logic        memory_address_latch_strobe = 1'b0, low_io_space_qualifier = 1'b1, relocation_strap = 1'b1;
    logic [11:0] local_addr_in, local_addr_out, local_addr_oe_n, memory_address_bus, memory_address_bus_oe_n;
    logic [11:0] peripheral_x_address_bus_in, peripheral_x_address_bus_out, peripheral_x_address_bus_oe_n;
    logic [11:0] system_address_bus_in, system_address_bus_out, system_address_bus_oe_n;
    logic [11:0] lv = 12'h000, xv = 12'h000, sv = 12'h000;
    logic        io_port_pair_select, keyboard_ctrl_select, port_b_select, nmi_mask_select, math_coproc_select;
    int          failures = 0, cmp_count = 0;
    typedef struct packed { logic [11:0] a; logic q; logic s; logic [4:0] sel; } dec_row_s;
    // Address, qualifier, strap, expected {pair, keyboard, port B, NMI, coprocessor}
    dec_row_s rows [16] = '{{12'h022, 2'b11, 5'h10}, {12'h023, 2'b11, 5'h10}, {12'h024, 2'b11, 5'h00},
        {12'h060, 2'b11, 5'h08}, {12'h064, 2'b11, 5'h08}, {12'h061, 2'b11, 5'h04}, {12'h062, 2'b11, 5'h00},
        {12'h070, 2'b11, 5'h02}, {12'h0e0, 2'b11, 5'h01}, {12'h0ff, 2'b11, 5'h01}, {12'h0df, 2'b11, 5'h00},
        {12'h100, 2'b11, 5'h00}, {12'h070, 2'b01, 5'h00}, {12'h470, 2'b11, 5'h00}, {12'h470, 2'b00, 5'h02},
        {12'h823, 2'b00, 5'h10}};
    wire [11:0] sel = {7'h00, io_port_pair_select, keyboard_ctrl_select, port_b_select, nmi_mask_select,
                       math_coproc_select};
    bus_party lp (.mclk(mclk), .dev_out(local_addr_out), .dev_oe_n(local_addr_oe_n), .ext_val(lv), .ext_en(1'b1),
                  .lvl(local_addr_in));
    bus_party xp (.mclk(mclk), .dev_out(peripheral_x_address_bus_out), .dev_oe_n(peripheral_x_address_bus_oe_n),
                  .ext_val(xv), .ext_en(1'b1), .lvl(peripheral_x_address_bus_in));
    bus_party sp (.mclk(mclk), .dev_out(system_address_bus_out), .dev_oe_n(system_address_bus_oe_n),
                  .ext_val(sv), .ext_en(1'b1), .lvl(system_address_bus_in));
    low_address_buffer_decode dut (.*);
    initial forever #2 mclk = ~mclk;
    // Waits n edges, then lets that edge's updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // Cuts a hang short
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
    initial begin
        tick(16);
        chk("mem enable", lab_pkg::OE_N_OFF, memory_address_bus_oe_n);
        $display("reset done");
        @(posedge mclk) sys_rst <= 1'b0;
        memory_address_latch_strobe <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk) lv <= rows[i].a;
            {low_io_space_qualifier, relocation_strap} <= {rows[i].q, rows[i].s}; // qualifier level
            tick(2);
            chk("selects", {7'h00, rows[i].sel}, sel);
        end
        $display("decode table done");
        // Master raised too, so hold must win
        @(posedge mclk) {dma_hold_acknowledge, bus_master, xv, sv} <= {2'b11, 12'ha5c, 12'h3c6};
        tick(1);
        chk("sys out", 12'ha5c, system_address_bus_out);
        chk("mem", 12'ha5c, memory_address_bus);
        chk("local out", 12'ha5c, local_addr_out);
        chk("local enable", lab_pkg::OE_N_ON, local_addr_oe_n);
        // The system bus still shows the slice's own hold value for one cycle after the turnaround
        @(posedge mclk) dma_hold_acknowledge <= 1'b0;
        tick(2);
        chk("x out", 12'h3c6, peripheral_x_address_bus_out);
        chk("mem", 12'h3c6, memory_address_bus);
        chk("local out", 12'h3c6, local_addr_out);
        $display("hold and master done");
        @(posedge mclk) {bus_master, refresh} <= 2'b01;
        tick(1);
        chk("row", lab_pkg::REFRESH_ROW_RESET, system_address_bus_out);
        chk("sys enable", lab_pkg::OE_N_ON, system_address_bus_oe_n);
        chk("selects", 12'h000, sel);
        chk("local enable", lab_pkg::OE_N_OFF, local_addr_oe_n);
        @(posedge mclk) refresh <= 1'b0;
        @(posedge mclk) refresh <= 1'b1;
        tick(1);
        chk("row", lab_pkg::REFRESH_ROW_RESET + 12'h001, system_address_bus_out);
        $display("refresh done");
        @(posedge mclk) {refresh, lv, xv} <= {1'b0, 12'h9b7, 12'h002};
        tick(1);
        @(posedge mclk) at_cycle_enable <= 1'b1;
        tick(1);
        chk("sys out", 12'h9b6, system_address_bus_out);
        chk("x out", 12'h9b4, peripheral_x_address_bus_out & 12'hffc);
        chk("x enable", 12'h003, peripheral_x_address_bus_oe_n);
        chk("mem", 12'h9b0, memory_address_bus & 12'hff0);
        chk("mem enable", 12'h00f, memory_address_bus_oe_n);
        @(posedge mclk) at_cycle_enable <= 1'b0;
        tick(1);
        chk("mem", 12'h9b7, memory_address_bus);
        chk("sys enable", lab_pkg::OE_N_OFF, system_address_bus_oe_n);
        // A frozen clock enable must hold the memory bus register
        @(posedge mclk) {clk_en, lv} <= {1'b0, 12'h111};
        tick(2);
        chk("mem", 12'h9b7, memory_address_bus);
        $display("AT and default done");
        end_of_test();
    end
endmodule : tb_top
